// ---- core/trre_pkg.sv ----
/*
 Constants and types shared by both ends of the read engine link.
 Assumes a single 20 MHz system clock on both ends.
*/
`default_nettype none
package trre_pkg;
   // ----------------------------------------------------------------
   // Timing.
   // ----------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int BUS_HZ = 400_000;
   localparam int QTR_CYC = (CLK_HZ + 4 * BUS_HZ - 1) / (4 * BUS_HZ);

   // ----------------------------------------------------------------
   // Addressing.
   // ----------------------------------------------------------------
   localparam int ADDR_W = 16;
   localparam logic [15:0] ADDR_RST = 16'h0000;
   localparam logic [6:0] MEM_ID = 7'h57;
   localparam logic [6:0] REG_ID = 7'h6F;
   localparam logic RW_RD = 1'h1;
   localparam logic RW_WR = 1'h0;
   localparam logic PIN_LOW = 1'h0;
   localparam logic [3:0] BIT_LAST = 4'h8;
   localparam logic [1:0] WADR_BYTES = 2'h2;

   // ----------------------------------------------------------------
   // Byte slots of a transfer, in bus order.
   // ----------------------------------------------------------------
   localparam logic [2:0] B_SLVW = 3'h0;
   localparam logic [2:0] B_HI = 3'h1;
   localparam logic [2:0] B_LO = 3'h2;
   localparam logic [2:0] B_SLVR = 3'h3;
   localparam logic [2:0] B_DATA = 3'h4;

   typedef enum logic [1:0] {TRRE_CUR, TRRE_RAND, TRRE_SET} trre_kind_t;
endpackage
`default_nettype wire

// ---- core/trre_if.sv ----
/*
 Open-drain clock and data wires between bus master and read engine.
 Assumes pull-ups: a wire is low only while some end drives it low.
*/
`timescale 1ns/100ps
`default_nettype none
interface trre_if;
   logic m_scl_o;
   logic m_scl_oe;
   logic m_sda_o;
   logic m_sda_oe;
   logic d_sda_o;
   logic d_sda_oe;
   logic scl_i;
   logic sda_i;

   // ----------------------------------------------------------------
   // Wired-AND resolution of the two lines.
   // ----------------------------------------------------------------
   assign scl_i = ~(m_scl_oe & ~m_scl_o);
   assign sda_i = ~((m_sda_oe & ~m_sda_o) | (d_sda_oe & ~d_sda_o));

   modport host(output m_scl_o, output m_scl_oe, output m_sda_o,
      output m_sda_oe, input scl_i, input sda_i);
   modport dev(output d_sda_o, output d_sda_oe, input scl_i, input sda_i);
endinterface
`default_nettype wire

// ---- core/trre_dev.sv ----
/*
 Device end: serial read engine of a clock/calendar memory slave.
 Assumes bus wires synchronous to clk and a user memory that shows
 rd_data for rd_addr/rd_space within one clk after they change.
*/
// Overview of operation
// R1 - Counter holds last read address plus one.
// R2 - Reset clears sixteen-bit address counter.
// R3 - Read slave byte acknowledged, eight bits sent.
// R4 - Master ends read at ninth clock.
// R5 - Random read: dummy write, repeated start, read.
// R6 - Acknowledge address bytes, then send addressed data.
// R7 - Stop after address bytes loads counter.
// R8 - After stop, ignore bus until start.
// R9 - Next current read uses loaded address.
// R10 - Master acknowledge sends next incremented byte.
// R11 - Counter crosses page and column boundaries.
// R12 - Counter wraps at end of space.
// R13 - Sequential read starts as current or random.
// R14 - Master ends read with no acknowledge, stop.
// R15 - Acknowledge only memory or register selector.
// R16 - Same slave byte in both random parts.
// R17 - Missing master acknowledge stops transmission.
// R18 - Master supplies two word address bytes.
// R19 - Bits sent MSB first, change while clock low.
`timescale 1ns/100ps
`default_nettype none
module trre_dev #(
   parameter int AW = trre_pkg::ADDR_W
) (
   input wire logic clk,
   input wire logic rstn,
   trre_if.dev bus,
   input wire logic [7:0] rd_data,
   output logic [AW-1:0] rd_addr,
   output logic rd_space,
   output logic rd_take,
   output logic active
);
   typedef enum logic [2:0] {
      TRRE_D_IDLE,
      TRRE_D_SLV,
      TRRE_D_WADR,
      TRRE_D_ACK,
      TRRE_D_TX,
      TRRE_D_MACK,
      TRRE_D_NXT
   } trre_dst_t;

   trre_dst_t st_ff;
   trre_dst_t nxt_st;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic scl_q_ff;
   logic sda_q_ff;
   logic [7:0] sh_ff;
   logic [7:0] tx_ff;
   logic [7:0] hi_ff;
   logic [1:0] wcnt_ff;
   logic to_tx_ff;
   logic oe_ff;
   logic take_ff;
   logic space_ff;
   logic active_ff;
   logic [AW-1:0] addr_ff;
   logic start_c;
   logic stop_c;
   logic rise_c;
   logic fall_c;
   logic id_hit;
   logic byte_end;
   logic load_c;

   // ----------------------------------------------------------------
   // Bus condition detection.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_q_ff <= 1'h1;
         sda_q_ff <= 1'h1;
      end else begin
         scl_q_ff <= bus.scl_i;
         sda_q_ff <= bus.sda_i;
      end
   end

   assign start_c = bus.scl_i & scl_q_ff & sda_q_ff & ~bus.sda_i;
   assign stop_c = bus.scl_i & scl_q_ff & ~sda_q_ff & bus.sda_i;
   assign rise_c = bus.scl_i & ~scl_q_ff;
   assign fall_c = ~bus.scl_i & scl_q_ff;
   assign byte_end = fall_c & (cnt_ff == trre_pkg::BIT_LAST);
   assign id_hit = (sh_ff[7:1] == trre_pkg::MEM_ID) ||
      (sh_ff[7:1] == trre_pkg::REG_ID); // [R15]
   assign load_c = fall_c & (((st_ff == TRRE_D_ACK) & to_tx_ff) |
      (st_ff == TRRE_D_NXT));

   // ----------------------------------------------------------------
   // Transfer state machine.
   // ----------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      if (start_c) begin
         nxt_st = TRRE_D_SLV;
         nxt_cnt = 4'h0;
      end else if (stop_c) begin
         nxt_st = TRRE_D_IDLE; // [R8]
         nxt_cnt = 4'h0;
      end else begin
         case (st_ff)
            TRRE_D_IDLE: begin
               nxt_st = TRRE_D_IDLE; // [R8]
            end
            TRRE_D_SLV: begin
               if (rise_c) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (byte_end) begin
                  nxt_st = id_hit ? TRRE_D_ACK : TRRE_D_IDLE; // [R15]
                  nxt_cnt = 4'h0;
               end
            end
            TRRE_D_WADR: begin
               if (rise_c) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (byte_end) begin
                  nxt_st = (wcnt_ff < trre_pkg::WADR_BYTES) ?
                     TRRE_D_ACK : TRRE_D_IDLE; // [R6]
                  nxt_cnt = 4'h0;
               end
            end
            TRRE_D_ACK: begin
               if (fall_c) begin
                  nxt_st = to_tx_ff ? TRRE_D_TX : TRRE_D_WADR; // [R3]
                  nxt_cnt = 4'h0;
               end
            end
            TRRE_D_TX: begin
               if (rise_c) begin
                  nxt_cnt = cnt_ff + 4'h1;
               end else if (byte_end) begin
                  nxt_st = TRRE_D_MACK;
                  nxt_cnt = 4'h0;
               end
            end
            TRRE_D_MACK: begin
               if (rise_c) begin
                  nxt_st = bus.sda_i ? TRRE_D_IDLE : TRRE_D_NXT; // [R17]
               end
            end
            TRRE_D_NXT: begin
               if (fall_c) begin
                  nxt_st = TRRE_D_TX; // [R10]
                  nxt_cnt = 4'h0;
               end
            end
            default: begin
               nxt_st = TRRE_D_IDLE;
               nxt_cnt = 4'h0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= TRRE_D_IDLE;
         cnt_ff <= 4'h0;
         active_ff <= 1'h0;
      end else begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         active_ff <= (nxt_st != TRRE_D_IDLE);
      end
   end

   // ----------------------------------------------------------------
   // Receive shifter for slave and word address bytes.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sh_ff <= 8'h00;
      end else if (rise_c && ((st_ff == TRRE_D_SLV) ||
            (st_ff == TRRE_D_WADR))) begin
         sh_ff <= {sh_ff[6:0], bus.sda_i};
      end
   end

   // ----------------------------------------------------------------
   // Data line drive: acknowledges and read data.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         oe_ff <= 1'h0;
         tx_ff <= 8'h00;
         to_tx_ff <= 1'h0;
         take_ff <= 1'h0;
      end else begin
         take_ff <= 1'h0;
         if (start_c || stop_c) begin
            oe_ff <= 1'h0;
         end else if (fall_c) begin
            case (st_ff)
               TRRE_D_SLV: begin
                  oe_ff <= byte_end & id_hit; // [R3] [R15]
                  to_tx_ff <= (sh_ff[0] == trre_pkg::RW_RD);
               end
               TRRE_D_WADR: begin
                  oe_ff <= byte_end &
                     (wcnt_ff < trre_pkg::WADR_BYTES); // [R6]
                  to_tx_ff <= 1'h0;
               end
               TRRE_D_ACK, TRRE_D_NXT: begin
                  if (load_c) begin
                     tx_ff <= rd_data; // [R3] [R6] [R13]
                     oe_ff <= ~rd_data[7]; // [R19]
                     take_ff <= 1'h1;
                  end else begin
                     oe_ff <= 1'h0;
                  end
               end
               TRRE_D_TX: begin
                  if (byte_end) begin
                     oe_ff <= 1'h0;
                  end else begin
                     oe_ff <= ~tx_ff[6]; // [R19]
                     tx_ff <= {tx_ff[6:0], 1'h0};
                  end
               end
               default: begin
                  oe_ff <= 1'h0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Read address counter.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         addr_ff <= AW'(trre_pkg::ADDR_RST); // [R2]
         hi_ff <= 8'h00;
         wcnt_ff <= 2'h0;
         space_ff <= 1'h0;
      end else if (byte_end) begin
         if ((st_ff == TRRE_D_SLV) && id_hit) begin
            space_ff <= (sh_ff[7:1] == trre_pkg::REG_ID);
            wcnt_ff <= 2'h0;
         end else if ((st_ff == TRRE_D_WADR) && (wcnt_ff == 2'h0)) begin
            hi_ff <= sh_ff;
            wcnt_ff <= 2'h1;
         end else if ((st_ff == TRRE_D_WADR) && (wcnt_ff == 2'h1)) begin
            addr_ff <= AW'({hi_ff, sh_ff}); // [R7] [R9]
            wcnt_ff <= 2'h2;
         end else if (st_ff == TRRE_D_TX) begin
            addr_ff <= addr_ff + AW'(1); // [R1] [R10] [R11] [R12]
         end
      end
   end

   // ----------------------------------------------------------------
   // Outputs.
   // ----------------------------------------------------------------
   assign bus.d_sda_o = trre_pkg::PIN_LOW;
   assign bus.d_sda_oe = oe_ff;
   assign rd_addr = addr_ff;
   assign rd_space = space_ff;
   assign rd_take = take_ff;
   assign active = active_ff;
endmodule // trre_dev
`default_nettype wire

// ---- core/trre_host.sv ----
/*
 Bus master end: issues current, random and set-address reads and
 queues received bytes in a small FIFO. Assumes one clock, clk.
*/
`timescale 1ns/100ps
`default_nettype none
module trre_fifo #(
   parameter int W = 8,
   parameter int D = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int PW = (D > 1) ? $clog2(D) : 1;
   localparam int CW = $clog2(D + 1);
   logic [W-1:0] mem_ff [D];
   logic [PW-1:0] wr_ff;
   logic [PW-1:0] rd_ff;
   logic [CW-1:0] cnt_ff;
   logic push;
   logic pop;

   assign in_ready = (cnt_ff != CW'(D));
   assign out_valid = (cnt_ff != CW'(0));
   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;
   assign out_data = mem_ff[rd_ff];

   for (genvar i = 0; i < D; i++) begin : g_ent
      always_ff @(posedge clk) begin
         if (push && (wr_ff == PW'(i))) begin
            mem_ff[i] <= in_data;
         end
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wr_ff <= '0;
         rd_ff <= '0;
         cnt_ff <= '0;
      end else begin
         if (push) begin
            wr_ff <= (wr_ff == PW'(D - 1)) ? '0 : wr_ff + PW'(1);
         end
         if (pop) begin
            rd_ff <= (rd_ff == PW'(D - 1)) ? '0 : rd_ff + PW'(1);
         end
         cnt_ff <= cnt_ff + CW'(push) - CW'(pop);
      end
   end
endmodule // trre_fifo

module trre_host #(
   parameter int QTR = trre_pkg::QTR_CYC,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic rstn,
   trre_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire trre_pkg::trre_kind_t cmd_kind,
   input wire logic cmd_reg,
   input wire logic [15:0] cmd_addr,
   input wire logic [7:0] cmd_len,
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [7:0] rd_data,
   output logic nack_err
);
   typedef enum logic [1:0] {TRRE_H_IDLE, TRRE_H_START, TRRE_H_BIT,
      TRRE_H_STOP} trre_hst_t;

   trre_hst_t st_ff;
   logic [15:0] div_ff;
   logic [1:0] ph_ff;
   logic [3:0] bit_ff;
   logic [2:0] byte_ff;
   logic [7:0] left_ff;
   logic [15:0] addr_ff;
   logic [7:0] rxsh_ff;
   trre_pkg::trre_kind_t kind_ff;
   logic reg_ff;
   logic ack_ff;
   logic scl_oe_ff;
   logic sda_oe_ff;
   logic err_ff;
   logic rdy_ff;
   logic tick;
   logic rx;
   logic ackslot;
   logic push_ready;
   logic go;
   logic out_bit;
   logic [7:0] tx_byte;
   logic [6:0] id;

   // ----------------------------------------------------------------
   // Quarter-bit enable divider.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_ff <= 16'h0000;
      end else begin
         div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
      end
   end
   assign tick = (div_ff == 16'(QTR - 1));

   // ----------------------------------------------------------------
   // Byte to send and bit to drive.
   // ----------------------------------------------------------------
   assign id = reg_ff ? trre_pkg::REG_ID : trre_pkg::MEM_ID; // [R16]
   assign rx = (byte_ff == trre_pkg::B_DATA);
   assign ackslot = (bit_ff == trre_pkg::BIT_LAST);
   always_comb begin
      case (byte_ff)
         trre_pkg::B_SLVW: tx_byte = {id, trre_pkg::RW_WR}; // [R5]
         trre_pkg::B_HI: tx_byte = addr_ff[15:8]; // [R18]
         trre_pkg::B_LO: tx_byte = addr_ff[7:0]; // [R18]
         trre_pkg::B_SLVR: tx_byte = {id, trre_pkg::RW_RD}; // [R5]
         default: tx_byte = 8'hFF;
      endcase
      if (ackslot) begin
         out_bit = rx ? (left_ff <= 8'h01) : 1'h1; // [R10] [R14]
      end else begin
         out_bit = rx ? 1'h1 : tx_byte[3'(4'h7 - bit_ff)];
      end
   end

   // Received bytes wait here; a full queue holds the clock low.
   assign go = tick & ~((st_ff == TRRE_H_BIT) & ackslot & rx &
      (ph_ff == 2'h0) & ~push_ready);

   trre_fifo #(.W(8), .D(DEPTH)) u_fifo (
      .clk(clk),
      .rstn(rstn),
      .in_valid(go & (st_ff == TRRE_H_BIT) & ackslot & rx &
         (ph_ff == 2'h0)),
      .in_ready(push_ready),
      .in_data(rxsh_ff),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // ----------------------------------------------------------------
   // Sequencer for start, bits and stop.
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         st_ff <= TRRE_H_IDLE;
         ph_ff <= 2'h0;
         bit_ff <= 4'h0;
         byte_ff <= trre_pkg::B_SLVW;
         left_ff <= 8'h00;
         addr_ff <= 16'h0000;
         kind_ff <= trre_pkg::TRRE_CUR;
         reg_ff <= 1'h0;
         rxsh_ff <= 8'h00;
         ack_ff <= 1'h1;
         scl_oe_ff <= 1'h0;
         sda_oe_ff <= 1'h0;
         err_ff <= 1'h0;
         rdy_ff <= 1'h1;
      end else begin
         err_ff <= 1'h0;
         if (st_ff == TRRE_H_IDLE) begin
            if (cmd_valid && rdy_ff) begin
               rdy_ff <= 1'h0;
               kind_ff <= cmd_kind;
               reg_ff <= cmd_reg;
               addr_ff <= cmd_addr;
               left_ff <= cmd_len;
               byte_ff <= (cmd_kind == trre_pkg::TRRE_CUR) ?
                  trre_pkg::B_SLVR : trre_pkg::B_SLVW; // [R13]
               ph_ff <= 2'h0;
               st_ff <= TRRE_H_START;
            end
         end else if (go) begin
            ph_ff <= ph_ff + 2'h1;
            case (st_ff)
               TRRE_H_START: begin
                  case (ph_ff)
                     2'h0: begin
                        scl_oe_ff <= 1'h1;
                        sda_oe_ff <= 1'h0;
                     end
                     2'h1: scl_oe_ff <= 1'h0;
                     2'h2: sda_oe_ff <= 1'h1;
                     default: begin
                        scl_oe_ff <= 1'h1;
                        bit_ff <= 4'h0;
                        st_ff <= TRRE_H_BIT;
                     end
                  endcase
               end
               TRRE_H_BIT: begin
                  case (ph_ff)
                     2'h0: sda_oe_ff <= ~out_bit;
                     2'h1: scl_oe_ff <= 1'h0;
                     2'h2: begin
                        if (ackslot) begin
                           ack_ff <= bus.sda_i;
                        end else begin
                           rxsh_ff <= {rxsh_ff[6:0], bus.sda_i};
                        end
                     end
                     default: begin
                        scl_oe_ff <= 1'h1;
                        bit_ff <= bit_ff + 4'h1;
                        if (ackslot) begin
                           bit_ff <= 4'h0;
                           if (rx) begin
                              left_ff <= left_ff - 8'h01;
                              if (left_ff <= 8'h01) begin
                                 st_ff <= TRRE_H_STOP; // [R4] [R14]
                              end
                           end else if (ack_ff) begin
                              err_ff <= 1'h1;
                              st_ff <= TRRE_H_STOP;
                           end else if (byte_ff == trre_pkg::B_LO) begin
                              byte_ff <= trre_pkg::B_SLVR;
                              st_ff <= (kind_ff == trre_pkg::TRRE_SET) ?
                                 TRRE_H_STOP : TRRE_H_START; // [R5] [R7]
                           end else begin
                              byte_ff <= byte_ff + 3'h1;
                           end
                        end
                     end
                  endcase
               end
               TRRE_H_STOP: begin
                  case (ph_ff)
                     2'h0: begin
                        scl_oe_ff <= 1'h1;
                        sda_oe_ff <= 1'h1;
                     end
                     2'h1: scl_oe_ff <= 1'h0;
                     2'h2: sda_oe_ff <= 1'h0;
                     default: begin
                        rdy_ff <= 1'h1;
                        st_ff <= TRRE_H_IDLE;
                     end
                  endcase
               end
               default: st_ff <= TRRE_H_IDLE;
            endcase
         end
      end
   end

   assign bus.m_scl_o = trre_pkg::PIN_LOW;
   assign bus.m_scl_oe = scl_oe_ff;
   assign bus.m_sda_o = trre_pkg::PIN_LOW;
   assign bus.m_sda_oe = sda_oe_ff;
   assign cmd_ready = rdy_ff;
   assign nack_err = err_ff;
endmodule // trre_host
`default_nettype wire

// ---- sim/trre_assertions.sv ----
/*
 Checker of the open-drain link between the read engine host and device.
 Assumes one clock and a host that only sends slave bytes the device owns.
*/
`timescale 1ns/100ps
`default_nettype none
module trre_assertions (
   input wire logic clk,
   input wire logic rstn,
   input wire logic m_scl_o,
   input wire logic m_scl_oe,
   input wire logic m_sda_o,
   input wire logic m_sda_oe,
   input wire logic d_sda_o,
   input wire logic d_sda_oe,
   input wire logic scl_i,
   input wire logic sda_i
);
   // ----------------------------------------------------------------
   // Bit and byte position since the last start.
   // ----------------------------------------------------------------
   logic scl_ff;
   logic sda_ff;
   logic rw_ff;
   logic [3:0] bit_ff;
   logic [2:0] byte_ff;
   logic rise;
   logic start;
   logic ack_rise;
   assign rise = scl_i & ~scl_ff;
   assign start = scl_i & scl_ff & sda_ff & ~sda_i;
   assign ack_rise = rise & (bit_ff == 4'h8);
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         scl_ff <= 1'h1;
         sda_ff <= 1'h1;
      end else begin
         scl_ff <= scl_i;
         sda_ff <= sda_i;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bit_ff <= 4'h0;
         byte_ff <= 3'h0;
      end else if (start) begin
         bit_ff <= 4'h0;
         byte_ff <= 3'h0;
      end else if (rise && bit_ff == 4'h9) begin
         bit_ff <= 4'h1;
         byte_ff <= (byte_ff == 3'h7) ? byte_ff : byte_ff + 3'h1;
      end else if (rise) begin
         bit_ff <= bit_ff + 4'h1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rw_ff <= 1'h0;
      end else if (rise && bit_ff == 4'h7 && byte_ff == 3'h0) begin
         rw_ff <= sda_i;
      end
   end

   // ----------------------------------------------------------------
   // Properties.
   // ----------------------------------------------------------------
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_stop;
      scl_i && scl_ff && !sda_ff && sda_i;
   endsequence
   sequence s_nack;
      ack_rise && rw_ff && byte_ff != 3'h0 && sda_i;
   endsequence
   sequence s_quiet;
      !d_sda_oe [*8];
   endsequence

   a_pins_open_drain: assert property (!m_scl_o && !m_sda_o
      && !d_sda_o)
      else $error("link output value not low");
   a_sda_scl_low: assert property ($changed(d_sda_oe) |-> !scl_i)
      else $error("device data changed while clock high");
   a_start_released: assert property (start |-> !d_sda_oe)
      else $error("device drove data at start");
   a_slave_ack: assert property (ack_rise && byte_ff == 3'h0
      |-> d_sda_oe)
      else $error("slave byte not acknowledged");
   a_word_ack: assert property (ack_rise && !rw_ff && byte_ff != 3'h0
      && byte_ff < 3'h3 |-> d_sda_oe && !m_scl_oe && !m_sda_oe)
      else $error("word address byte not acknowledged");
   a_master_slot: assert property (ack_rise && rw_ff
      && byte_ff != 3'h0 |-> !d_sda_oe)
      else $error("device held data in master acknowledge slot");
   a_nack_quiet: assert property (s_nack |=> s_quiet)
      else $error("device drove data after missing acknowledge");
   a_stop_quiet: assert property (s_stop |=> s_quiet)
      else $error("device drove data after stop");
endmodule // trre_assertions
`default_nettype wire

// ---- sim/trre_tb.sv ----
/*
 Self-checking bench: host and device joined by the link interface.
 Assumes a memory model that answers rd_addr and rd_space at once.
*/
`timescale 1ns/100ps
`default_nettype none
module trre_tb;
   logic clk = 1'h0;
   logic rstn = 1'h0;
   logic cmd_valid = 1'h0;
   logic cmd_ready;
   trre_pkg::trre_kind_t cmd_kind = trre_pkg::TRRE_CUR;
   logic cmd_reg = 1'h0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [7:0] cmd_len = 8'h00;
   logic rd_valid;
   logic rd_ready = 1'h0;
   logic [7:0] rd_data;
   logic nack_err;
   logic [15:0] dev_addr;
   logic dev_space;
   logic [7:0] dev_data;
   logic dev_take;
   logic dev_active;
   logic hold = 1'h0;
   logic [15:0] exp_addr = 16'h0000;
   logic [7:0] exp_q[$];
   int failures = 0;
   int check_count = 0;
   int takes = 0;
   int exp_takes = 0;
   int j;

   trre_if u_trre_if();
   trre_dev u_trre_dev(.clk(clk), .rstn(rstn), .bus(u_trre_if),
      .rd_data(dev_data), .rd_addr(dev_addr), .rd_space(dev_space),
      .rd_take(dev_take), .active(dev_active));
   trre_host #(.QTR(2), .DEPTH(4)) u_trre_host(.clk(clk), .rstn(rstn),
      .bus(u_trre_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
      .cmd_kind(cmd_kind), .cmd_reg(cmd_reg), .cmd_addr(cmd_addr),
      .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
      .rd_data(rd_data), .nack_err(nack_err));
   trre_assertions u_trre_assertions(.clk(clk), .rstn(rstn),
      .m_scl_o(u_trre_if.m_scl_o), .m_scl_oe(u_trre_if.m_scl_oe),
      .m_sda_o(u_trre_if.m_sda_o), .m_sda_oe(u_trre_if.m_sda_oe),
      .d_sda_o(u_trre_if.d_sda_o), .d_sda_oe(u_trre_if.d_sda_oe),
      .scl_i(u_trre_if.scl_i), .sda_i(u_trre_if.sda_i));

   // ----------------------------------------------------------------
   // Memory model, checks and command driver.
   // ----------------------------------------------------------------
   function automatic logic [7:0] mem(input logic [15:0] a, input logic s);
      return a[7:0] ^ {a[11:8], a[15:12]} ^ (s ? 8'h5A : 8'h00);
   endfunction
   assign dev_data = mem(dev_addr, dev_space);

   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      check_count++;
      if (seen !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && check_count > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic issue(input trre_pkg::trre_kind_t k, input logic r,
      input logic [15:0] a, input logic [7:0] n);
      int i;
      @(posedge clk);
      cmd_valid <= 1'h1;
      cmd_kind <= k;
      cmd_reg <= r;
      cmd_addr <= a;
      cmd_len <= n;
      if (k != trre_pkg::TRRE_CUR) exp_addr = a;
      for (i = 0; k != trre_pkg::TRRE_SET && i < ((n == 0) ? 1 : n); i++) begin
         exp_q.push_back(mem(exp_addr, r));
         exp_addr++;
         exp_takes++;
      end
      @(posedge clk);
      cmd_valid <= 1'h0;
      @(posedge clk);
      for (i = 0; i < 40000 && cmd_ready !== 1'h1; i++) @(posedge clk);
      #1;
      check("rd_addr", dev_addr, exp_addr);
      check("rd_take", 16'(takes), 16'(exp_takes));
      check("active", {15'h0, dev_active}, 16'h0000);
   endtask

   always @(posedge clk) begin : mon
      logic [15:0] e;
      if (rstn && rd_valid === 1'h1 && rd_ready === 1'h1) begin
         e = (exp_q.size() > 0) ? {8'h00, exp_q.pop_front()} : 16'hFFFF;
         check("rd_data", {8'h00, rd_data}, e);
      end
      if (rstn && nack_err !== 1'h0) check("nack_err", 16'h1, 16'h0);
      if (rstn && dev_take === 1'h1) takes++;
   end

   always @(posedge clk) rd_ready <= !hold && ($urandom_range(3) != 0);

   initial begin
      forever #25 clk = ~clk;
   end

   initial begin
      repeat (80000) @(posedge clk);
      failures++;
      end_sim;
   end

   // ----------------------------------------------------------------
   // Main sequence.
   // ----------------------------------------------------------------
   initial begin
      void'($urandom(79016));
      repeat (10) @(posedge clk);
      rstn <= 1'h1;
      issue(trre_pkg::TRRE_CUR, 1'h0, 16'h1234, 8'h02);
      issue(trre_pkg::TRRE_RAND, 1'h0, 16'hFFFE, 8'h04);
      issue(trre_pkg::TRRE_SET, 1'h1, 16'h003E, 8'h09);
      issue(trre_pkg::TRRE_CUR, 1'h1, 16'h0000, 8'h03);
      issue(trre_pkg::TRRE_RAND, 1'h1, 16'h00FF, 8'h00);
      hold <= 1'h1;
      fork
         issue(trre_pkg::TRRE_CUR, 1'h0, 16'h0000, 8'h07);
         begin
            repeat (2000) @(posedge clk);
            hold <= 1'h0;
         end
      join
      for (j = 0; j < 6; j++) begin
         issue(trre_pkg::trre_kind_t'($urandom_range(2)),
            1'($urandom_range(1)), 16'($urandom), 8'($urandom_range(5)));
      end
      for (j = 0; j < 5000 && exp_q.size() != 0; j++) @(posedge clk);
      check("left", 16'(exp_q.size()), 16'h0000);
      end_sim;
   end
endmodule // trre_tb
`default_nettype wire
